// [logic/boost_ctrl_params.svh]
// Register offsets, field positions, reset values and timing for the boost control register bank.
`ifndef BOOST_CTRL_PARAMS_SVH
`define BOOST_CTRL_PARAMS_SVH

`define ADDR_BOOST_STATUS 8'hc0
`define ADDR_BOOST_IRQ_MASK 8'hc1
`define ADDR_BOOST_VOLTAGE_CONFIG 8'hc5
`define ADDR_BOOST_ENABLE_CONFIG 8'hc6
`define ADDR_BOOST_FAULT_SEQUENCE 8'hc7
`define ADDR_BOOST_DELAY_CONFIG 8'hc8
`define ADDR_AUX_REGULATOR_CONFIG 8'hc9

`define RST_BOOST_IRQ_MASK 8'hdc
`define RST_BOOST_VOLTAGE_CONFIG 8'h98
`define RST_BOOST_ENABLE_CONFIG 8'h0f
`define RST_BOOST_FAULT_SEQUENCE 8'h77
`define RST_BOOST_DELAY_CONFIG 8'h42
`define RST_AUX_REGULATOR_CONFIG 8'h66

`define BIT_POWER_GOOD 7
`define BIT_OVERVOLTAGE 6
`define BIT_CURRENT_SHUTDOWN 4
`define BIT_CURRENT_FAULT 3
`define BIT_CURRENT_WARNING 2
`define BIT_AUX_AUTOSTART 7
`define BIT_SWITCH_FAULT_MASK 6
`define BIT_DIRECT_ENABLE 3
`define BIT_HOLD_ON_SEQ_DROP 2
`define BIT_SLEEP_OFF_ENABLE 1
`define BIT_DEEP_SLEEP_OFF_ENABLE 0
`define BIT_REGULATOR_FAULT_IGNORE 7
`define BIT_RESET_OUTPUT_LINK 6
`define BIT_SYSTEM_FAULT_IGNORE 7

`define CORE_CLK_PERIOD_NS 20
`define TURN_ON_STEP_NS 250000
`define TURN_OFF_STEP_NS 1000000
`define TURN_ON_STEP_CYCLES (`TURN_ON_STEP_NS / `CORE_CLK_PERIOD_NS)
`define TURN_OFF_STEP_CYCLES (`TURN_OFF_STEP_NS / `CORE_CLK_PERIOD_NS)

`define I2C_DEVICE_ADDR 7'h25

`endif

// [logic/boost_ctrl_pkg.sv]
// Types shared by the boost control register bank and its bench.
package boost_ctrl_pkg;

	typedef enum logic [1:0] {
		BST_OFF = 2'b00,
		DIRECT_ENABLE_WAIT = 2'b01,
		DIRECT_ENABLE = 2'b10,
		BST_OFF_WAIT = 2'b11
	} boost_state_e;

	typedef enum logic [3:0] {
		SER_IDLE = 4'h0,
		SER_ADDR = 4'h1,
		SER_ACK_ADDR = 4'h2,
		SER_PTR = 4'h3,
		SER_ACK_PTR = 4'h4,
		SER_WDATA = 4'h5,
		SER_ACK_WDATA = 4'h6,
		SER_RDATA = 4'h7,
		SER_RACK = 4'h8,
		SER_RLOAD = 4'h9
	} serial_state_e;

	typedef struct packed {
		logic out_good;
		logic out_over;
		logic isw_shutdown;
		logic isw_fault;
		logic isw_warning;
		logic vcc_above_uvlo;
		logic seq_enable;
		logic sleep_mode;
		logic deep_sleep_mode;
	} sense_s;

	typedef struct packed {
		logic boost_on;
		logic [5:0] boost_voltage_code;
		logic switch_fault_react;
		logic aux_on;
		logic [5:0] aux_voltage_code;
		logic [1:0] aux_current_limit;
		logic system_fault_req;
	} drive_s;

endpackage

// [logic/boost_ctrl_status_regs.sv]
// Boost regulator control and status register bank with its serial control port.
`timescale 1ns/100ps
`include "boost_ctrl_params.svh"

module boost_ctrl_status_regs #(
	parameter int ON_STEP_CYCLES = `TURN_ON_STEP_CYCLES,
	parameter int OFF_STEP_CYCLES = `TURN_OFF_STEP_CYCLES,
	parameter logic [6:0] DEVICE_ADDR = `I2C_DEVICE_ADDR
) (
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic SCL,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	input boost_ctrl_pkg::sense_s SENSE,
	output boost_ctrl_pkg::drive_s DRIVE,
	output logic IRQ_OUT_N,
	output logic SYSTEM_RESET_OUT_N
);
	import boost_ctrl_pkg::*;

	initial begin
		if (ON_STEP_CYCLES < 1 || ON_STEP_CYCLES * 64 >= (1 << 24)) begin
			$error("ON_STEP_CYCLES out of range");
		end
		if (OFF_STEP_CYCLES < 1 || OFF_STEP_CYCLES * 15 >= (1 << 24)) begin
			$error("OFF_STEP_CYCLES out of range");
		end
	end

	// Every outside level passes two flip-flops; only the second stage is used.
	localparam int NSYNC = $bits(sense_s) + 2;
	logic [NSYNC-1:0] sync_a;
	logic [NSYNC-1:0] sync_b;
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			sync_a <= {2'b11, {(NSYNC-2){1'b0}}};
			sync_b <= {2'b11, {(NSYNC-2){1'b0}}};
		end else begin
			sync_a <= {SCL, SDA_IN, SENSE};
			sync_b <= sync_a;
		end
	end

	sense_s sense;
	logic scl_s;
	logic sda_s;
	assign sense = sync_b[NSYNC-3:0];
	assign scl_s = sync_b[NSYNC-1];
	assign sda_s = sync_b[NSYNC-2];

	logic scl_d;
	logic sda_d;
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign bus_start = scl_s & scl_d & sda_d & ~sda_s;
	assign bus_stop = scl_s & scl_d & ~sda_d & sda_s;

	// Register storage.
	logic [7:0] irq_mask;
	logic [7:0] voltage_config;
	logic [7:0] enable_config;
	logic [7:0] fault_sequence;
	logic [7:0] delay_config;
	logic [7:0] aux_config;
	logic [7:0] status;
	logic [3:0] flag;

	logic wr_stb;
	logic rd_stb;
	logic [7:0] ptr;
	logic [7:0] shift;

	// Serial port state.
	serial_state_e ser_state;
	logic [3:0] bit_cnt;
	logic read_dir;
	logic [7:0] tx;

	function automatic logic [7:0] read_mux(input logic [7:0] addr);
		case (addr)
			`ADDR_BOOST_STATUS: read_mux = status;
			`ADDR_BOOST_IRQ_MASK: read_mux = irq_mask;
			`ADDR_BOOST_VOLTAGE_CONFIG: read_mux = voltage_config;
			`ADDR_BOOST_ENABLE_CONFIG: read_mux = enable_config;
			`ADDR_BOOST_FAULT_SEQUENCE: read_mux = fault_sequence;
			`ADDR_BOOST_DELAY_CONFIG: read_mux = delay_config;
			`ADDR_AUX_REGULATOR_CONFIG: read_mux = aux_config;
			default: read_mux = 8'h00;
		endcase
	endfunction

	logic [7:0] rd_data;
	assign rd_data = read_mux(ptr);
	assign SDA_OUT = 1'b0;

	// The status register counts as read when its byte is loaded for shifting out.
	assign rd_stb = scl_fall && (ser_state == SER_RLOAD || (ser_state == SER_ACK_ADDR && read_dir))
		&& ptr == `ADDR_BOOST_STATUS;
	assign wr_stb = scl_fall && ser_state == SER_WDATA && bit_cnt == 4'h8;

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			ser_state <= SER_IDLE;
			bit_cnt <= 4'h0;
			read_dir <= 1'b0;
			shift <= 8'h00;
			tx <= 8'h00;
			ptr <= 8'h00;
			SDA_OE <= 1'b0;
		end else if (bus_stop) begin
			ser_state <= SER_IDLE;
			SDA_OE <= 1'b0;
		end else if (bus_start) begin
			ser_state <= SER_ADDR;
			bit_cnt <= 4'h0;
			SDA_OE <= 1'b0;
		end else if (scl_rise) begin
			case (ser_state)
				SER_ADDR, SER_PTR, SER_WDATA: begin
					shift <= {shift[6:0], sda_s};
					bit_cnt <= bit_cnt + 4'h1;
				end
				SER_RACK: begin
					ser_state <= sda_s ? SER_IDLE : SER_RLOAD;
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (ser_state)
				SER_ADDR: begin
					if (bit_cnt == 4'h8) begin
						if (shift[7:1] == DEVICE_ADDR) begin
							ser_state <= SER_ACK_ADDR;
							read_dir <= shift[0];
							SDA_OE <= 1'b1;
						end else begin
							ser_state <= SER_IDLE;
						end
					end
				end
				SER_ACK_ADDR, SER_RLOAD: begin
					if (ser_state == SER_RLOAD || read_dir) begin
						ser_state <= SER_RDATA;
						SDA_OE <= ~rd_data[7];
						tx <= {rd_data[6:0], 1'b0};
						bit_cnt <= 4'h1;
						ptr <= ptr + 8'h01;
					end else begin
						ser_state <= SER_PTR;
						SDA_OE <= 1'b0;
						bit_cnt <= 4'h0;
					end
				end
				SER_PTR: begin
					if (bit_cnt == 4'h8) begin
						ptr <= shift;
						ser_state <= SER_ACK_PTR;
						SDA_OE <= 1'b1;
					end
				end
				SER_WDATA: begin
					if (bit_cnt == 4'h8) begin
						ptr <= ptr + 8'h01;
						ser_state <= SER_ACK_WDATA;
						SDA_OE <= 1'b1;
					end
				end
				SER_ACK_PTR, SER_ACK_WDATA: begin
					ser_state <= SER_WDATA;
					SDA_OE <= 1'b0;
					bit_cnt <= 4'h0;
				end
				SER_RDATA: begin
					if (bit_cnt == 4'h8) begin
						ser_state <= SER_RACK;
						SDA_OE <= 1'b0;
					end else begin
						SDA_OE <= ~tx[7];
						tx <= {tx[6:0], 1'b0};
						bit_cnt <= bit_cnt + 4'h1;
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Host writes; the status register and unmapped addresses ignore writes.
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			irq_mask <= `RST_BOOST_IRQ_MASK;
			voltage_config <= `RST_BOOST_VOLTAGE_CONFIG;
			enable_config <= `RST_BOOST_ENABLE_CONFIG;
			fault_sequence <= `RST_BOOST_FAULT_SEQUENCE;
			delay_config <= `RST_BOOST_DELAY_CONFIG;
			aux_config <= `RST_AUX_REGULATOR_CONFIG;
		end else if (wr_stb) begin
			case (ptr)
				`ADDR_BOOST_IRQ_MASK: irq_mask <= shift;
				`ADDR_BOOST_VOLTAGE_CONFIG: voltage_config <= shift;
				`ADDR_BOOST_ENABLE_CONFIG: enable_config <= shift;
				`ADDR_BOOST_FAULT_SEQUENCE: fault_sequence <= shift;
				`ADDR_BOOST_DELAY_CONFIG: delay_config <= shift;
				`ADDR_AUX_REGULATOR_CONFIG: aux_config <= shift;
				default: begin
				end
			endcase
		end
	end

	// Sticky flags: a read arms the clear, which waits for the condition to end.
	// The live condition always wins over a pending clear, so no event is lost.
	logic [3:0] flag_cond;
	logic [3:0] read_seen;
	assign flag_cond = {sense.out_over, sense.isw_shutdown, sense.isw_fault, sense.isw_warning};

	generate
		for (genvar i = 0; i < 4; i++) begin : g_flag
			always_ff @(posedge CORE_CLK or negedge RESETN) begin
				if (!RESETN) begin
					flag[i] <= 1'b0;
					read_seen[i] <= 1'b0;
				end else if (flag_cond[i]) begin
					flag[i] <= 1'b1;
					read_seen[i] <= read_seen[i] | (rd_stb & flag[i]);
				end else if (flag[i] && (read_seen[i] || rd_stb)) begin
					flag[i] <= 1'b0;
					read_seen[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign status = {sense.out_good, flag[3], 1'b0, flag[2], flag[1], flag[0], 2'b00};

	// Mask bits withhold events from the interrupt only; the flags run on regardless.
	logic irq_any;
	assign irq_any = (~sense.out_good & ~irq_mask[`BIT_POWER_GOOD])
		| (flag[3] & ~irq_mask[`BIT_OVERVOLTAGE])
		| (flag[2] & ~irq_mask[`BIT_CURRENT_SHUTDOWN])
		| (flag[1] & ~irq_mask[`BIT_CURRENT_FAULT])
		| (flag[0] & ~irq_mask[`BIT_CURRENT_WARNING]);

	// Boost sequencing.
	boost_state_e bst_state;
	logic [23:0] delay_cnt;
	logic good_seen;
	logic under_volt;
	logic reg_fault;
	logic switch_fault;
	logic sleep_kill;
	logic kill;
	logic want_on;
	logic [23:0] on_cycles;
	logic [23:0] off_cycles;

	always_comb begin
		if (delay_config[6:4] == 3'h0) begin
			on_cycles = 24'h000000;
		end else begin
			on_cycles = 24'(ON_STEP_CYCLES) << (delay_config[6:4] - 3'h1);
		end
	end
	assign off_cycles = 24'(OFF_STEP_CYCLES * int'(delay_config[3:0]));

	// Undervoltage counts only once the output has been good, or the start-up ramp would trip it.
	assign under_volt = good_seen & ~sense.out_good;
	assign reg_fault = ~fault_sequence[`BIT_REGULATOR_FAULT_IGNORE] & (sense.out_over | under_volt);
	assign switch_fault = ~voltage_config[`BIT_SWITCH_FAULT_MASK] & sense.isw_shutdown;
	assign sleep_kill = (sense.sleep_mode & enable_config[`BIT_SLEEP_OFF_ENABLE])
		| (sense.deep_sleep_mode & enable_config[`BIT_DEEP_SLEEP_OFF_ENABLE]);
	assign kill = reg_fault | switch_fault | sleep_kill;
	assign want_on = ~kill & (enable_config[`BIT_DIRECT_ENABLE] | sense.seq_enable
		| (enable_config[`BIT_HOLD_ON_SEQ_DROP] & bst_state == DIRECT_ENABLE));

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			bst_state <= BST_OFF;
			delay_cnt <= 24'h000000;
		end else begin
			case (bst_state)
				BST_OFF: begin
					if (want_on && on_cycles == 24'h000000) begin
						bst_state <= DIRECT_ENABLE;
					end else if (want_on) begin
						bst_state <= DIRECT_ENABLE_WAIT;
						delay_cnt <= on_cycles - 24'h000001;
					end
				end
				DIRECT_ENABLE_WAIT: begin
					if (!want_on) begin
						bst_state <= BST_OFF;
					end else if (delay_cnt == 24'h000000) begin
						bst_state <= DIRECT_ENABLE;
					end else begin
						delay_cnt <= delay_cnt - 24'h000001;
					end
				end
				DIRECT_ENABLE: begin
					// Faults and sleep entry act at once; only a dropped enable waits.
					if (kill || (!want_on && off_cycles == 24'h000000)) begin
						bst_state <= BST_OFF;
					end else if (!want_on) begin
						bst_state <= BST_OFF_WAIT;
						delay_cnt <= off_cycles - 24'h000001;
					end
				end
				BST_OFF_WAIT: begin
					if (kill || delay_cnt == 24'h000000) begin
						bst_state <= BST_OFF;
					end else if (want_on) begin
						bst_state <= DIRECT_ENABLE;
					end else begin
						delay_cnt <= delay_cnt - 24'h000001;
					end
				end
				default: bst_state <= BST_OFF;
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			good_seen <= 1'b0;
		end else if (bst_state != DIRECT_ENABLE && bst_state != BST_OFF_WAIT) begin
			good_seen <= 1'b0;
		end else if (sense.out_good) begin
			good_seen <= 1'b1;
		end
	end

	// Registered outputs.
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			DRIVE <= '0;
			IRQ_OUT_N <= 1'b1;
			SYSTEM_RESET_OUT_N <= 1'b1;
		end else begin
			DRIVE.boost_on <= bst_state == DIRECT_ENABLE || bst_state == BST_OFF_WAIT;
			DRIVE.boost_voltage_code <= voltage_config[5:0];
			DRIVE.switch_fault_react <= switch_fault;
			DRIVE.aux_on <= voltage_config[`BIT_AUX_AUTOSTART] & sense.vcc_above_uvlo;
			DRIVE.aux_voltage_code <= aux_config[5:0];
			DRIVE.aux_current_limit <= aux_config[7:6];
			DRIVE.system_fault_req <= ~delay_config[`BIT_SYSTEM_FAULT_IGNORE] & (sense.out_over | under_volt);
			IRQ_OUT_N <= ~irq_any;
			SYSTEM_RESET_OUT_N <= ~(fault_sequence[`BIT_RESET_OUTPUT_LINK]
				& (bst_state == BST_OFF || bst_state == DIRECT_ENABLE_WAIT));
		end
	end

endmodule // boost_ctrl_status_regs

// [dv/boost_chk.sv]
// Port-level checker for the boost control register bank.
`timescale 1ns/100ps
module boost_chk (
	input wire logic CORE_CLK,
	input wire logic RESETN,
	input wire logic SDA_OE,
	input boost_ctrl_pkg::sense_s SENSE,
	input boost_ctrl_pkg::drive_s DRIVE,
	input wire logic IRQ_OUT_N,
	input wire logic SYSTEM_RESET_OUT_N
);
	logic [3:0] age;
	logic [3:0] ev;
	logic cause;
	logic up;
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);
	// Outputs settle from reset values during the first edges, so change checks wait.
	assign up = age == 4'hf;
	assign cause = !SENSE.out_good | SENSE.out_over | SENSE.isw_shutdown | SENSE.isw_fault | SENSE.isw_warning;
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) age <= 4'h0;
		else if (!up) age <= age + 4'h1;
	end
	always_ff @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) ev <= 4'h0;
		else ev <= {ev[2:0], cause};
	end
	property p_vcode;
		up && $changed(DRIVE.boost_voltage_code) |-> ##[0:3] SDA_OE;
	endproperty
	a_vcode: assert property (p_vcode) else $error("voltage code moved without a write");
	property p_alim;
		up && $changed(DRIVE.aux_current_limit) |-> ##[0:3] SDA_OE;
	endproperty
	a_alim: assert property (p_alim) else $error("aux limit moved without a write");
	property p_avolt;
		up && $changed(DRIVE.aux_voltage_code) |-> ##[0:3] SDA_OE;
	endproperty
	a_avolt: assert property (p_avolt) else $error("aux voltage moved without a write");
	property p_aux;
		DRIVE.aux_on |-> $past(SENSE.vcc_above_uvlo, 2) || $past(SENSE.vcc_above_uvlo, 3);
	endproperty
	a_aux: assert property (p_aux) else $error("aux on without bias supply");
	property p_sysf;
		DRIVE.system_fault_req |-> $past(SENSE.out_over, 3) || !$past(SENSE.out_good, 3);
	endproperty
	a_sysf: assert property (p_sysf) else $error("system fault without output fault");
	property p_swf;
		DRIVE.switch_fault_react |-> $past(SENSE.isw_shutdown, 2) || $past(SENSE.isw_shutdown, 3);
	endproperty
	a_swf: assert property (p_swf) else $error("switch reaction without fault");
	property p_rst;
		up && DRIVE.boost_on |-> SYSTEM_RESET_OUT_N;
	endproperty
	a_rst: assert property (p_rst) else $error("reset out low with boost on");
	property p_irq;
		up && $fell(IRQ_OUT_N) |-> (|ev) or (##[0:3] SDA_OE);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt without cause");
endmodule // boost_chk
bind boost_ctrl_status_regs boost_chk chk (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .SDA_OE(SDA_OE),
	.SENSE(SENSE), .DRIVE(DRIVE), .IRQ_OUT_N(IRQ_OUT_N), .SYSTEM_RESET_OUT_N(SYSTEM_RESET_OUT_N));

// [dv/i2c_host.sv]
// Serial bus host model that reaches the register bank as a processor would.
`timescale 1ns/100ps
module i2c_host (
	input wire logic clk,
	input wire logic dev_pull,
	output logic scl,
	output logic sda
);
	logic pull = 1'b0;
	logic acked = 1'b1;
	// Open-drain line with a pull-up, so a released line reads high.
	assign sda = !(pull | dev_pull);
	initial scl = 1'b1;
	task automatic hold(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Data moves only while the clock is low, two cycles after the fall.
	task automatic bit_io(input logic b, output logic r);
		hold(2);
		pull = !b;
		hold(4);
		scl = 1'b1;
		hold(4);
		r = sda;
		scl = 1'b0;
	endtask
	task automatic byte_io(input logic [7:0] d, input logic chk, output logic [7:0] q);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
		bit_io(1'b1, r);
		if (chk && r) acked = 1'b0;
	endtask
	task automatic start();
		hold(2);
		pull = 1'b0;
		hold(2);
		scl = 1'b1;
		hold(4);
		pull = 1'b1;
		hold(4);
		scl = 1'b0;
	endtask
	task automatic xfer(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
		input logic rd, output logic [7:0] q);
		acked = 1'b1;
		start();
		byte_io({a, 1'b0}, 1'b1, q);
		byte_io(p, 1'b1, q);
		if (rd) begin
			start();
			byte_io({a, 1'b1}, 1'b1, q);
			byte_io(8'hff, 1'b0, q);
		end else begin
			byte_io(d, 1'b1, q);
		end
		hold(2);
		pull = 1'b1;
		hold(2);
		scl = 1'b1;
		hold(4);
		pull = 1'b0;
		hold(4);
	endtask
endmodule // i2c_host

// [dv/tb.sv]
// Self-checking bench for the boost control register bank.
`timescale 1ns/100ps
module tb;
	import boost_ctrl_pkg::*;
	localparam logic [7:0] ADR [6] = '{8'hc1, 8'hc5, 8'hc6, 8'hc7, 8'hc8, 8'hc9};
	localparam logic [7:0] RST [6] = '{8'hdc, 8'h98, 8'h0f, 8'h77, 8'h42, 8'h66};
	localparam logic [7:0] TBL [9] = '{8'h81, 8'h00, 8'h09, 8'h41, 8'h00, 8'ha4, 8'h85, 8'h92, 8'h83};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic scl, sda, oe, sda_out, irq_n, sro_n;
	sense_s sense = 9'h108;
	drive_s drv;
	logic [7:0] seen, q;
	logic [7:0] exp_q [$];
	logic [31:0] rng = 32'd87646;
	int num_errors = 0;
	int cmp_count = 0;
	event seen_ev;
	always #10 clk = ~clk;
	i2c_host host (.clk(clk), .dev_pull(oe), .scl(scl), .sda(sda));
	boost_ctrl_status_regs #(.ON_STEP_CYCLES(4), .OFF_STEP_CYCLES(8)) dut (.CORE_CLK(clk), .RESETN(rst_n),
		.SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(oe), .SENSE(sense), .DRIVE(drv),
		.IRQ_OUT_N(irq_n), .SYSTEM_RESET_OUT_N(sro_n));
	function automatic logic [7:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng[7:0];
	endfunction
	task automatic check(input logic [7:0] got, input logic [7:0] want);
		cmp_count++;
		if (got !== want) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask
	task automatic print_verdict();
		$display("checks=%0d errors=%0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// The delay keeps two notes from sharing a time step, which the watcher would miss.
	task automatic note(input logic [7:0] got, input logic [7:0] want);
		exp_q.push_back(want);
		seen = got;
		-> seen_ev;
		#1;
	endtask
	always @(seen_ev) check(seen, exp_q.pop_front());
	task automatic note1(input logic g, input logic w);
		note({7'h0, g}, {7'h0, w});
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic sn(input int i, input logic v);
		@(negedge clk);
		sense[i] = v;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.xfer(7'h25, a, d, 1'b0, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] want);
		host.xfer(7'h25, a, 8'h00, 1'b1, q);
		note(q, want);
	endtask
	initial begin
		#2000000;
		num_errors++;
		print_verdict();
	end
	initial begin
		logic [7:0] v, f, e;
		int n;
		int on_n [8];
		int off_n [8];
		wt(6);
		rst_n = 1'b1;
		wt(4);
		rd(8'hc0, 8'h80);
		rd(8'hc2, 8'h00);
		for (int i = 0; i < 6; i++) rd(ADR[i], RST[i]);
		for (int i = 0; i < 6; i++) begin
			v = rnd();
			wr(ADR[i], v);
			rd(ADR[i], v);
			if (i == 1) note({2'b0, drv.boost_voltage_code}, {2'b0, v[5:0]});
			if (i == 5) note({drv.aux_current_limit, drv.aux_voltage_code}, v);
		end
		host.xfer(7'h24, 8'hc9, 8'h00, 1'b0, q);
		note1(host.acked, 1'b0);
		note1(sda_out, 1'b0);
		rd(8'hc9, v);
		wr(8'hc0, 8'h7f);
		rd(8'hc0, 8'h80);
		wr(8'hc5, 8'h18);
		wr(8'hc7, 8'hc0);
		wr(8'hc8, 8'h11);
		for (int m = 0; m < 2; m++) begin
			wr(8'hc1, m ? 8'h00 : 8'hff);
			for (int k = 0; k < 4; k++) begin
				f = 8'h80 | (8'h01 << ((k == 0) ? 6 : 5 - k));
				sn(7 - k, 1'b1);
				wt(8);
				note1(irq_n, m == 0);
				sn(7 - k, 1'b0);
				wt(8);
				rd(8'hc0, f);
				rd(8'hc0, 8'h80);
				wt(4);
				note1(irq_n, 1'b1);
				sn(7 - k, 1'b1);
				wt(8);
				rd(8'hc0, f);
				rd(8'hc0, f);
				sn(7 - k, 1'b0);
				wt(8);
				rd(8'hc0, 8'h80);
			end
		end
		wr(8'hc1, 8'h80);
		sn(8, 1'b0);
		wt(8);
		note1(irq_n, 1'b1);
		rd(8'hc0, 8'h00);
		wr(8'hc1, 8'h00);
		note1(irq_n, 1'b0);
		sn(8, 1'b1);
		wt(8);
		rd(8'hc0, 8'h80);
		note1(irq_n, 1'b1);
		wr(8'hc5, 8'h80);
		sn(3, 1'b0);
		wt(6);
		note1(drv.aux_on, 1'b0);
		sn(3, 1'b1);
		wt(6);
		note1(drv.aux_on, 1'b1);
		wr(8'hc5, 8'h00);
		note1(drv.aux_on, 1'b0);
		wr(8'hc6, 8'h00);
		wt(300);
		for (int c = 1; c < 8; c++) begin
			wr(8'hc8, {1'b0, 3'(c), 4'(c)});
			sn(2, 1'b1);
			n = 0;
			while (drv.boost_on !== 1'b1 && n < 900) begin
				@(negedge clk);
				n++;
			end
			on_n[c] = n;
			wt(2);
			note1(sro_n, 1'b1);
			sn(2, 1'b0);
			n = 0;
			while (drv.boost_on !== 1'b0 && n < 900) begin
				@(negedge clk);
				n++;
			end
			off_n[c] = n;
			wt(2);
			note1(sro_n, 1'b0);
			note(8'(on_n[c] - on_n[1]), 8'(4 * ((1 << (c - 1)) - 1)));
			note(8'(off_n[c] - off_n[1]), 8'(8 * (c - 1)));
		end
		wr(8'hc8, 8'h11);
		for (int i = 0; i < 9; i++) begin
			e = TBL[i];
			wr(8'hc6, {4'h0, e[7:4]});
			@(negedge clk);
			sense[2:0] = e[3:1];
			wt(200);
			note1(drv.boost_on, e[0]);
		end
		sn(7, 1'b1);
		wt(8);
		note1(drv.boost_on, 1'b1);
		note1(drv.system_fault_req, 1'b1);
		wr(8'hc8, 8'h91);
		note1(drv.system_fault_req, 1'b0);
		wr(8'hc7, 8'h40);
		note1(drv.boost_on, 1'b0);
		sn(7, 1'b0);
		wt(20);
		note1(drv.boost_on, 1'b1);
		wr(8'hc5, 8'h40);
		sn(6, 1'b1);
		wt(8);
		note1(drv.switch_fault_react, 1'b0);
		note1(drv.boost_on, 1'b1);
		wr(8'hc5, 8'h00);
		note1(drv.switch_fault_react, 1'b1);
		note1(drv.boost_on, 1'b0);
		sn(6, 1'b0);
		wt(20);
		wr(8'hc7, 8'h80);
		wr(8'hc6, 8'h00);
		wt(200);
		note1(sro_n, 1'b1);
		wt(4);
		print_verdict();
	end
endmodule // tb
